// ==== logic/timer_pwm_consts.svh ====
`ifndef TIMER_PWM_CONSTS_SVH
`define TIMER_PWM_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_TRIG       8'h04
`define OFS_PERIOD     8'h08
`define OFS_PERIOD_BUF 8'h0c
`define OFS_CC         8'h10
`define OFS_CC_BUF     8'h14
`define OFS_COUNT      8'h18
`define OFS_STATUS     8'h1c
`define OFS_MASK       8'h20
// Control register fields
`define CTRL_EN        0
`define CTRL_MODE_LO   1
`define CTRL_MODE_HI   3
`define CTRL_DIR_LO    4
`define CTRL_DIR_HI    5
`define CTRL_PSC_LO    6
`define CTRL_PSC_HI    8
`define CTRL_EXTCNT    9
`define CTRL_KILL_P    10
`define CTRL_KILL_N    11
`define CTRL_SWAP      12
`define CTRL_DT_LO     16
`define CTRL_DT_HI     23
// Status and mask bits
`define ST_TC          0
`define ST_CC          1
// Reset values
`define RST_CTRL       32'h0000_0000
`define RST_TRIG       32'h0000_0000
`define RST_PERIOD     32'hffff_ffff
`endif

// ==== logic/timer_pwm_pkg.sv ====
package timer_pwm_pkg;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_CMP  = 6'h01,
    MODE_CAP  = 6'h02,
    MODE_QUAD = 6'h04,
    MODE_PWM  = 6'h08,
    MODE_PRS  = 6'h10,
    MODE_DT   = 6'h20
  } mode_t;
  // Counting direction field
  typedef enum logic [1:0] {
    DIR_UP   = 2'h0,
    DIR_DOWN = 2'h1,
    DIR_UPDN = 2'h2
  } dir_t;
  // Trigger sensitivity field
  typedef enum logic [1:0] {
    TRG_RISE  = 2'h0,
    TRG_FALL  = 2'h1,
    TRG_BOTH  = 2'h2,
    TRG_LEVEL = 2'h3
  } trig_t;
endpackage

// ==== logic/trig_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module trig_detect (
  input  wire logic                  mclk,  // Peripheral clock
  input  wire logic                  rst_n, // Async reset, active low
  input  wire logic                  pin,   // Raw trigger from outside logic
  input  wire timer_pwm_pkg::trig_t  cfg,   // Sensitivity
  output logic                       hit,   // Trigger active this cycle
  output logic                       lvl    // Synchronised level
);
  logic [2:0] sh;      // sync1, sync2, previous
  logic [2:0] next_sh; // Next shift state

  // Shift the pin through two stages, then keep one more for edges
  always_comb begin
    next_sh = {sh[1:0], pin};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 3'h0;
    end else begin
      sh <= next_sh;
    end
  end

  assign lvl = sh[1];

  // Only stages two and three are looked at, never the first
  always_comb begin
    case (cfg)
      timer_pwm_pkg::TRG_RISE:  hit = sh[1] & ~sh[2]; // [R9]
      timer_pwm_pkg::TRG_FALL:  hit = ~sh[1] & sh[2]; // [R9]
      timer_pwm_pkg::TRG_BOTH:  hit = sh[1] ^ sh[2];  // [R9]
      default:                  hit = sh[1];          // [R9]
    endcase
  end

  AST_TRIG_RISE: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
    (cfg == timer_pwm_pkg::TRG_RISE && sh[1] && !sh[2]) |-> hit ##1 !hit)
    else $error("rising trigger not a single pulse");
endmodule
`default_nettype wire

// ==== logic/timer_pwm_channel.sv ====
// Function
// [R1] Modes: compare, capture, quadrature, PWM, pseudo-random, dead-time
// [R2] Count up, down, or up/down
// [R3] Prescaler divides by powers of two, 1..128
// [R4] Period and compare/capture are double buffered
// [R5] Pulse outputs on underflow, overflow, match
// [R6] Terminal count interrupt, on wrap
// [R7] Capture/compare interrupt on capture or match
// [R8] Start, reload, stop, count, capture triggers
// [R9] Triggers act on rise, fall, both, level
// [R10] Kill input forces outputs to set state
// [R11] Counter width is a 16/32 parameter
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_consts.svh"
module timer_pwm_channel #(
  parameter int CW = 32                   // Counter width, 16 or 32 [R11]
) (
  input  wire logic        mclk,          // Peripheral clock, 20 MHz
  input  wire logic        rst_n,         // Async reset, active low
  input  wire logic [7:0]  addr,          // Register byte address
  input  wire logic [31:0] wdata,         // Write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [31:0] rdata,         // Read data, cycle after rd
  input  wire logic [4:0]  trig_in,       // start, reload, stop, count, capture
  input  wire logic        kill,          // Force outputs
  output logic             pwm_out,       // Line output
  output logic             pwm_out_n,     // Complementary line output
  output logic             ovf,           // Overflow pulse
  output logic             unf,           // Underflow pulse
  output logic             cc_evt,        // Capture/compare pulse
  output logic             irq            // Level interrupt
);
  localparam int T_START = 0;
  localparam int T_RELOAD = 1;
  localparam int T_STOP = 2;
  localparam int T_COUNT = 3;
  localparam int T_CAP = 4;

  logic [31:0]           ctrl;       // Control
  logic [31:0]           trig_cfg;   // Trigger sensitivities
  logic [CW-1:0]         period;     // Active period
  logic [CW-1:0]         period_buf; // Buffered period
  logic [CW-1:0]         cc;         // Active compare / captured value
  logic [CW-1:0]         cc_buf;     // Buffered compare / older capture
  logic [CW-1:0]         cnt;        // Counter
  logic [1:0]            status;     // Sticky events
  logic [1:0]            mask;       // Interrupt mask
  logic                  running;    // Counter running
  logic                  going_dn;   // Up/down phase
  logic [6:0]            psc;        // Prescaler
  logic [7:0]            dt_cnt;     // Dead-time countdown
  logic                  raw_q;      // Previous raw line
  logic [1:0]            kill_sync;  // Kill synchroniser
  logic [4:0]            hit;        // Trigger hits
  logic [4:0]            lvl;        // Trigger levels
  logic                  qa_q;       // Previous quadrature phase A
  timer_pwm_pkg::mode_t  mode;       // Decoded mode
  timer_pwm_pkg::dir_t   dir;        // Decoded direction
  logic                  tick;       // Counting step this cycle
  logic                  tc;         // Terminal count this cycle
  logic                  match;      // Compare match this cycle
  logic                  cap;        // Capture this cycle
  logic                  raw;        // Unshaped modulation line

  logic [31:0]   next_ctrl, next_trig_cfg, next_rdata;
  logic [CW-1:0] next_period, next_period_buf, next_cc, next_cc_buf, next_cnt;
  logic [1:0]    next_status, next_mask, next_kill_sync;
  logic          next_running, next_going_dn, next_raw_q, next_qa_q;
  logic          next_pwm_out, next_pwm_out_n, next_ovf, next_unf, next_cc_evt;
  logic [6:0]    next_psc;
  logic [7:0]    next_dt_cnt;

  // Zero-extends a counter-width value to the bus
  function automatic logic [31:0] ext(input logic [CW-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[CW-1:0] = v;
    return r;
  endfunction

  // Mode field to one-hot state; unused codes fall back to compare
  function automatic timer_pwm_pkg::mode_t dec_mode(input logic [2:0] f);
    case (f)
      3'h1:    return timer_pwm_pkg::MODE_CAP;
      3'h2:    return timer_pwm_pkg::MODE_QUAD;
      3'h3:    return timer_pwm_pkg::MODE_PWM;
      3'h4:    return timer_pwm_pkg::MODE_PRS;
      3'h5:    return timer_pwm_pkg::MODE_DT;
      default: return timer_pwm_pkg::MODE_CMP;
    endcase
  endfunction

  // One trigger detector per trigger input
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_trig
      trig_detect u_trig (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (trig_in[gi]),
        .cfg   (timer_pwm_pkg::trig_t'(trig_cfg[2*gi+1 -: 2])),
        .hit   (hit[gi]),
        .lvl   (lvl[gi])
      );
    end
  endgenerate

  // Decode and event terms shared by both groups
  always_comb begin
    mode  = dec_mode(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);                  // [R1]
    dir   = timer_pwm_pkg::dir_t'(ctrl[`CTRL_DIR_HI:`CTRL_DIR_LO]);
    // Prescale ratio 2^p: step when the low p bits are all ones
    tick  = 1'b0;
    if (mode == timer_pwm_pkg::MODE_QUAD) begin
      tick = lvl[T_COUNT] & ~qa_q;                                       // [R1]
    end else if (ctrl[`CTRL_EXTCNT]) begin
      tick = hit[T_COUNT];                                               // [R8]
    end else begin
      tick = &(psc | ~(7'((8'h1 << ctrl[`CTRL_PSC_HI:`CTRL_PSC_LO]) - 8'h1))); // [R3]
    end
    tick  = tick & running & ctrl[`CTRL_EN];
    tc    = tick && ((dir == timer_pwm_pkg::DIR_UP && cnt == period) ||
                     (dir != timer_pwm_pkg::DIR_UP && cnt == '0));        // [R6]
    cap   = hit[T_CAP] && mode == timer_pwm_pkg::MODE_CAP;               // [R7]
    match = tick && mode != timer_pwm_pkg::MODE_CAP && cnt == cc;        // [R7]
    raw   = cnt < cc;
  end

  // Counter, prescaler, buffers, modulation lines
  always_comb begin
    next_psc       = psc + 7'h1;
    next_cnt       = cnt;
    next_running   = running;
    next_going_dn  = going_dn;
    next_period    = period;
    next_cc        = cc;
    next_cc_buf    = cc_buf;
    next_ovf       = 1'b0;
    next_unf       = 1'b0;
    next_cc_evt    = cap | match;                                        // [R5]
    next_qa_q      = lvl[T_COUNT];
    next_raw_q     = raw;
    next_dt_cnt    = (raw != raw_q) ? ctrl[`CTRL_DT_HI:`CTRL_DT_LO] :
                     (dt_cnt != 8'h0) ? dt_cnt - 8'h1 : 8'h0;
    // Software writes to active or buffered values
    if (wr && addr == `OFS_PERIOD)     next_period = wdata[CW-1:0];
    if (wr && addr == `OFS_CC)         next_cc = wdata[CW-1:0];
    if (wr && addr == `OFS_CC_BUF)     next_cc_buf = wdata[CW-1:0];
    // Start and stop; stop wins when both arrive together
    if (hit[T_START])                  next_running = 1'b1;              // [R8]
    if (hit[T_STOP])                   next_running = 1'b0;              // [R8]
    if (tick) begin
      if (mode == timer_pwm_pkg::MODE_QUAD) begin
        // Phase B level picks direction on each phase A rise
        next_cnt = lvl[T_CAP] ? cnt - CW'(1) : cnt + CW'(1);             // [R1]
      end else if (mode == timer_pwm_pkg::MODE_PRS) begin
        next_cnt = {cnt[CW-2:0], ~(cnt[CW-1] ^ cnt[CW-2] ^ cnt[0])};     // [R1]
      end else begin
        case (dir)
          timer_pwm_pkg::DIR_UP: begin
            next_cnt = (cnt == period) ? '0 : cnt + CW'(1);              // [R2]
            next_ovf = (cnt == period);                                  // [R5]
          end
          timer_pwm_pkg::DIR_DOWN: begin
            next_cnt = (cnt == '0) ? period : cnt - CW'(1);              // [R2]
            next_unf = (cnt == '0);                                      // [R5]
          end
          default: begin
            // Turn around at the period and at zero
            if (!going_dn && cnt == period) begin
              next_going_dn = 1'b1;
              next_cnt      = cnt - CW'(1);
              next_ovf      = 1'b1;                                      // [R5]
            end else if (going_dn && cnt == '0) begin
              next_going_dn = 1'b0;
              next_cnt      = cnt + CW'(1);
              next_unf      = 1'b1;                                      // [R5]
            end else begin
              next_cnt = going_dn ? cnt - CW'(1) : cnt + CW'(1);         // [R2]
            end
          end
        endcase
      end
    end
    // Buffered values only take effect at a wrap, so a cycle is never torn
    if (tc && ctrl[`CTRL_SWAP]) begin
      next_period = period_buf;                                          // [R4]
      if (mode != timer_pwm_pkg::MODE_CAP) next_cc = cc_buf;             // [R4]
    end
    if (cap) begin
      next_cc_buf = cc;                                                  // [R4]
      next_cc     = cnt;                                                 // [R7]
    end
    if (hit[T_RELOAD]) begin
      next_running  = 1'b1;                                              // [R8]
      next_going_dn = 1'b0;
      next_cnt      = (dir == timer_pwm_pkg::DIR_DOWN) ? period : '0;
    end
    // Line shaping; dead time delays each rising side
    case (mode)
      timer_pwm_pkg::MODE_DT: begin
        next_pwm_out   = raw & (dt_cnt == 8'h0) & (raw == raw_q);        // [R1]
        next_pwm_out_n = ~raw & (dt_cnt == 8'h0) & (raw == raw_q);       // [R1]
      end
      timer_pwm_pkg::MODE_PWM, timer_pwm_pkg::MODE_PRS: begin
        next_pwm_out   = raw;                                            // [R1]
        next_pwm_out_n = ~raw;
      end
      default: begin
        next_pwm_out   = 1'b0;
        next_pwm_out_n = 1'b1;
      end
    endcase
    if (kill_sync[1]) begin
      next_pwm_out   = ctrl[`CTRL_KILL_P];                               // [R10]
      next_pwm_out_n = ctrl[`CTRL_KILL_N];                               // [R10]
    end
    next_kill_sync = {kill_sync[0], kill};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psc <= 7'h0;            cnt <= '0;            running <= 1'b0;
      going_dn <= 1'b0;       period <= CW'(`RST_PERIOD); cc <= '0;
      cc_buf <= '0;           ovf <= 1'b0;          unf <= 1'b0;
      cc_evt <= 1'b0;         qa_q <= 1'b0;         raw_q <= 1'b0;
      dt_cnt <= 8'h0;         pwm_out <= 1'b0;      pwm_out_n <= 1'b0;
      kill_sync <= 2'h0;
    end else begin
      psc <= next_psc;        cnt <= next_cnt;      running <= next_running;
      going_dn <= next_going_dn; period <= next_period; cc <= next_cc;
      cc_buf <= next_cc_buf;  ovf <= next_ovf;      unf <= next_unf;
      cc_evt <= next_cc_evt;  qa_q <= next_qa_q;    raw_q <= next_raw_q;
      dt_cnt <= next_dt_cnt;  pwm_out <= next_pwm_out; pwm_out_n <= next_pwm_out_n;
      kill_sync <= next_kill_sync;
    end
  end

  // Register writes, sticky status and read mux
  always_comb begin
    next_ctrl       = ctrl;
    next_trig_cfg   = trig_cfg;
    next_period_buf = period_buf;
    next_mask       = mask;
    next_status     = status;
    if (wr) begin
      case (addr)
        `OFS_CTRL:       next_ctrl = wdata;
        `OFS_TRIG:       next_trig_cfg = {22'h0, wdata[9:0]};
        `OFS_PERIOD_BUF: next_period_buf = wdata[CW-1:0];
        `OFS_MASK:       next_mask = wdata[1:0];
        `OFS_STATUS:     next_status = status & ~wdata[1:0];
        default:         next_mask = mask;
      endcase
    end
    // A new event beats a clear in the same cycle
    if (tc)            next_status[`ST_TC] = 1'b1;                       // [R6]
    if (cap | match)   next_status[`ST_CC] = 1'b1;                       // [R7]
    case (addr)
      `OFS_CTRL:       next_rdata = ctrl;
      `OFS_TRIG:       next_rdata = trig_cfg;
      `OFS_PERIOD:     next_rdata = ext(period);
      `OFS_PERIOD_BUF: next_rdata = ext(period_buf);
      `OFS_CC:         next_rdata = ext(cc);
      `OFS_CC_BUF:     next_rdata = ext(cc_buf);
      `OFS_COUNT:      next_rdata = ext(cnt);
      `OFS_STATUS:     next_rdata = {30'h0, status};
      `OFS_MASK:       next_rdata = {30'h0, mask};
      default:         next_rdata = 32'h0;
    endcase
    if (!rd) next_rdata = 32'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RST_CTRL;   trig_cfg <= `RST_TRIG; period_buf <= CW'(`RST_PERIOD);
      mask <= 2'h0;        status <= 2'h0;        rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;   trig_cfg <= next_trig_cfg; period_buf <= next_period_buf;
      mask <= next_mask;   status <= next_status; rdata <= next_rdata;
    end
  end

  assign irq = |(status & mask);

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_seen;
    hit[T_STOP] && !hit[T_RELOAD];
  endsequence

  // Only a reload right after the stop may move the halted count
  AST_STOP_HALTS: assert property (s_stop_seen |=> !running ##1 (cnt == $past(cnt) || $past(hit[T_RELOAD]))) // [R8]
    else $error("stop trigger did not halt");
  AST_UP_WRAP: assert property (tick && dir == timer_pwm_pkg::DIR_UP && cnt == period && !hit[T_RELOAD] // [R2]
    && mode != timer_pwm_pkg::MODE_PRS && mode != timer_pwm_pkg::MODE_QUAD |=> cnt == '0 && ovf)
    else $error("up count did not wrap to zero");
  AST_PSC_DIV2: assert property (!ctrl[`CTRL_EXTCNT] && ctrl[`CTRL_PSC_HI:`CTRL_PSC_LO] == 3'h1 // [R3]
    && mode != timer_pwm_pkg::MODE_QUAD && tick |=> !tick)
    else $error("divide by two stepped twice in a row");
  AST_BUF_HOLD: assert property (wr && addr == `OFS_PERIOD_BUF && !tc // [R4]
    |=> period == $past(period))
    else $error("buffered period leaked into active");
  AST_UNF_CAUSE: assert property (unf |-> $past(tick) && $past(cnt) == '0) // [R5]
    else $error("underflow without zero count");
  AST_TC_IRQ: assert property (tc |=> status[`ST_TC] && (irq || !mask[`ST_TC])) // [R6]
    else $error("terminal count not flagged");
  AST_CAPTURE: assert property (cap |=> cc == $past(cnt) && cc_buf == $past(cc) && status[`ST_CC]) // [R7]
    else $error("capture did not latch count");
  AST_KILL: assert property (kill_sync[1] |=> pwm_out == $past(ctrl[`CTRL_KILL_P]) // [R10]
    && pwm_out_n == $past(ctrl[`CTRL_KILL_N]))
    else $error("kill did not force outputs");
  AST_DT_GAP: assert property (mode == timer_pwm_pkg::MODE_DT && !kill_sync[1] // [R1]
    |=> !(pwm_out && pwm_out_n))
    else $error("dead-time outputs overlap");
endmodule
`default_nettype wire

// ==== test/trig_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands in for the on-chip trigger sources and the kill source
module trig_source_model (
  input  wire logic       mclk,     // Peripheral clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic [4:0] req,      // One-cycle request per trigger
  input  wire logic [7:0] len,      // Cycles to hold a requested trigger
  input  wire logic       kill_req, // Kill wanted
  output logic      [4:0] trig_in,  // Trigger pins
  output logic            kill      // Kill pin
);
  logic [7:0] left [5]; // Remaining high cycles per trigger

  // Hold each trigger; never shorter than 2 cycles, or the edge is lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) left[i] <= 8'h00;
      kill <= 1'b0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (req[i]) left[i] <= (len < 8'h02) ? 8'h02 : len;
        else if (left[i] != 8'h00) left[i] <= left[i] - 8'h01;
      end
      kill <= kill_req;
    end
  end

  // Pin is high while its hold count runs
  always_comb begin
    for (int i = 0; i < 5; i++) trig_in[i] = (left[i] != 8'h00);
  end
endmodule
`default_nettype wire

// ==== test/timer_pwm_channel_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_consts.svh"
module timer_pwm_channel_tb;
  logic        mclk;           // 20 MHz clock
  logic        rst_n;          // Active-low reset
  logic [7:0]  addr;           // Register address
  logic [31:0] wdata;          // Write data
  logic        wr;             // Write strobe
  logic        rd;             // Read strobe
  logic [31:0] rdata;          // Read data
  logic [4:0]  trig_in;        // Trigger pins
  logic        kill;           // Kill pin
  logic        pwm_out;        // Line output
  logic        pwm_out_n;      // Complementary output
  logic        ovf;            // Overflow pulse
  logic        unf;            // Underflow pulse
  logic        cc_evt;         // Capture/compare pulse
  logic        irq;            // Interrupt line
  logic [4:0]  req;            // Trigger requests
  logic [7:0]  len;            // Trigger hold length
  logic        kill_req;       // Kill request
  int          err_count = 0;  // Mismatches
  int          n_compared = 0; // Comparisons
  int          ticks = 0;      // Timeout counter
  logic [31:0] v;              // Read scratch
  logic [31:0] c0;             // Earlier count
  int          c, hi, hn, bh;  // Cycle and level counts
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  row_t        rows [12];      // Write flag, address, data, expected read

  // 16-bit instance, so upper halves must read zero
  timer_pwm_channel #(.CW(16)) i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in), .kill(kill), .pwm_out(pwm_out),
    .pwm_out_n(pwm_out_n), .ovf(ovf), .unf(unf), .cc_evt(cc_evt), .irq(irq));
  trig_source_model i_src (.mclk(mclk), .rst_n(rst_n), .req(req), .len(len),
    .kill_req(kill_req), .trig_in(trig_in), .kill(kill));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Cut a hang short; the whole run needs about 2000 cycles
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Data is valid only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] q);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  task automatic fire(input int b, input logic [7:0] n);
    @(posedge mclk);
    req <= 5'(1 << b);
    len <= n;
    @(posedge mclk);
    req <= 5'h00;
  endtask

  // Cycles until the chosen pulse: 0 overflow, 1 underflow, 2 capture/compare
  task automatic wait_evt(input int which, output int cyc);
    logic s;
    cyc = 0;
    do begin
      @(posedge mclk);
      #1;
      cyc++;
      s = (which == 0) ? ovf : (which == 1) ? unf : cc_evt;
    end while (s !== 1'b1 && cyc < 1000);
  endtask

  // Counts high cycles of each output, and of both at once
  task automatic watch(input int n);
    hi = 0;
    hn = 0;
    bh = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      hi += int'(pwm_out === 1'b1);
      hn += int'(pwm_out_n === 1'b1);
      bh += int'(pwm_out === 1'b1 && pwm_out_n === 1'b1);
    end
  endtask

  function automatic logic [31:0] ctl(input int m, input int d, input int p, input int k);
    ctl = 32'h1 | 32'(m) << `CTRL_MODE_LO | 32'(d) << `CTRL_DIR_LO | 32'(p) << `CTRL_PSC_LO
        | 32'(k) << `CTRL_KILL_P;
  endfunction

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    req = 5'h00;
    len = 8'h02;
    kill_req = 1'b0;
    rows = '{'{0, `OFS_CTRL, 32'h0, 32'h0}, '{0, `OFS_TRIG, 32'h0, 32'h0},
             '{0, `OFS_PERIOD, 32'h0, 32'hffff}, '{0, `OFS_PERIOD_BUF, 32'h0, 32'hffff},
             '{0, `OFS_STATUS, 32'h0, 32'h0}, '{0, `OFS_MASK, 32'h0, 32'h0},
             '{0, `OFS_COUNT, 32'h0, 32'h0}, '{1, `OFS_PERIOD, 32'h1_0003, 32'h3},
             '{1, `OFS_CC_BUF, 32'h1234, 32'h1234}, '{1, `OFS_COUNT, 32'h55, 32'h0},
             '{1, 8'h24, 32'h1, 32'h0}, '{1, `OFS_CC, 32'h2, 32'h2}};
    repeat (5) @(posedge mclk);
    #1;
    check("reset_outputs", {26'h0, pwm_out, pwm_out_n, ovf, unf, cc_evt, irq}, 32'h0);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    done("reset");
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, v);
      check("register", v, rows[i].e);
    end
    done("registers");
    // Period 3 gives four ticks per wrap, each tick 2^p cycles long
    fire(0, 8'h03);
    // Slowest first, so the match test below runs at ratio 1
    for (int p = 7; p >= 0; p -= 3 + int'(p == 7)) begin
      wreg(`OFS_CTRL, ctl(0, 0, p, 0));
      repeat (3) wait_evt(0, c);
      check("overflow_gap", 32'(c), 32'(4 << p));
    end
    done("prescaler");
    repeat (3) wait_evt(2, c);
    check("match_gap", 32'(c), 32'h4);
    fire(2, 8'h03);
    repeat (8) @(posedge mclk);
    rreg(`OFS_STATUS, v);
    check("status", v, 32'h3);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wreg(`OFS_MASK, 32'h1);
    #1;
    check("irq_raised", {31'h0, irq}, 32'h1);
    wreg(`OFS_STATUS, 32'h3);
    #1;
    check("irq_cleared", {31'h0, irq}, 32'h0);
    done("interrupts");
    // Down wraps every 4 ticks, up/down underflows every 6
    fire(0, 8'h03);
    for (int d = 1; d < 3; d++) begin
      wreg(`OFS_CTRL, ctl(0, d, 0, 0));
      repeat (3) wait_evt(1, c);
      check("underflow_gap", 32'(c), 32'(2 + 2 * d));
    end
    done("directions");
    for (int m = 0; m < 6; m++) begin
      wreg(`OFS_CTRL, ctl(m, 0, 0, 0));
      repeat (4) @(posedge mclk);
      watch(8);
      if (m < 3) check("idle_levels", 32'(hi * 16 + hn), 32'h8);
      if (m == 3) check("pwm_duty", 32'(hi), 32'h4);
      if (m == 5) check("deadtime_overlap", 32'(bh), 32'h0);
    end
    done("modes");
    wreg(`OFS_CTRL, ctl(3, 0, 0, 1));
    @(posedge mclk);
    kill_req <= 1'b1;
    repeat (6) @(posedge mclk);
    watch(4);
    check("kill_levels", 32'(hi * 16 + hn), 32'h40);
    @(posedge mclk);
    kill_req <= 1'b0;
    done("kill");
    // Start armed for a falling edge must ignore the rising one
    fire(2, 8'h03);
    wreg(`OFS_PERIOD, 32'hffff);
    wreg(`OFS_TRIG, 32'h1);
    repeat (6) @(posedge mclk);
    rreg(`OFS_COUNT, c0);
    fire(0, 8'h08);
    repeat (4) @(posedge mclk);
    rreg(`OFS_COUNT, v);
    check("start_on_rise", v, c0);
    repeat (12) @(posedge mclk);
    rreg(`OFS_COUNT, v);
    check("start_on_fall", {31'h0, v !== c0}, 32'h1);
    done("trigger_edge");
    // Capture on a halted counter, so the latched value is known
    fire(2, 8'h03);
    wreg(`OFS_CTRL, ctl(1, 0, 0, 0));
    wreg(`OFS_STATUS, 32'h3);
    rreg(`OFS_COUNT, c0);
    fire(4, 8'h03);
    wait_evt(2, c);
    check("capture_pulse", 32'(c), 32'h3);
    rreg(`OFS_CC, v);
    check("capture_value", v, c0);
    rreg(`OFS_CC_BUF, v);
    check("capture_old", v, 32'h2);
    rreg(`OFS_STATUS, v);
    check("capture_flag", v, 32'h2);
    done("capture");
    // Reload clears the count and starts it; read six steps later
    fire(1, 8'h03);
    repeat (8) @(posedge mclk);
    rreg(`OFS_COUNT, v);
    check("reload_count", v, 32'h6);
    done("reload");
    // Reset in mid-run puts outputs and registers back
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("midrun_outputs", {26'h0, pwm_out, pwm_out_n, ovf, unf, cc_evt, irq}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rreg(`OFS_CC, v);
    check("midrun_cc", v, 32'h0);
    rreg(`OFS_PERIOD, v);
    check("midrun_period", v, 32'hffff);
    done("midrun_reset");
    summarize();
  end
endmodule
`default_nettype wire
